// ==== uie_pkg.sv ====
package uie_pkg;

  // register port geometry
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // setup packet buffer, one byte per address
  localparam logic [15:0] SETUP_REQUEST_TYPE_ADDR = 16'hff28;
  localparam logic [15:0] SETUP_REQUEST_CODE_ADDR = 16'hff29;
  localparam logic [15:0] SETUP_VALUE_LO_ADDR = 16'hff2a;
  localparam logic [15:0] SETUP_VALUE_HI_ADDR = 16'hff2b;
  localparam logic [15:0] SETUP_INDEX_LO_ADDR = 16'hff2c;
  localparam logic [15:0] SETUP_INDEX_HI_ADDR = 16'hff2d;
  localparam logic [15:0] SETUP_LENGTH_LO_ADDR = 16'hff2e;
  localparam logic [15:0] SETUP_LENGTH_HI_ADDR = 16'hff2f;
  localparam int SETUP_BYTES = 8;
  localparam int SETUP_IDX_W = 3;

  // endpoint configuration and event registers
  localparam logic [15:0] IN_ENDPOINT_CONFIG_ADDR = 16'hff08;
  localparam logic [15:0] EVENT_STATUS_ADDR = 16'hff10;
  localparam logic [15:0] EVENT_MASK_ADDR = 16'hff11;

  // configuration byte fields, common to both layouts
  localparam int CFG_ON_BIT = 7;
  localparam int CFG_ISO_BIT = 6;
  // non-isochronous layout
  localparam int CFG_TOGGLE_BIT = 5;
  localparam int CFG_DUAL_BIT = 4;
  localparam int CFG_STALL_BIT = 3;
  localparam int CFG_IRQ_GATE_BIT = 2;
  localparam logic [7:0] CFG_RESERVED_MASK = 8'h03;
  // isochronous layout
  localparam int CFG_OVERRUN_BIT = 5;
  localparam int CFG_FRAME_BYTES_MSB = 4;
  localparam int FRAME_W = 5;
  localparam logic [7:0] CFG_RESET = 8'h00;

  // event status bits
  localparam int EV_XFER_DONE = 0;
  localparam int EV_SETUP_RCVD = 1;
  localparam int EV_OVERRUN = 2;
  localparam int EV_W = 3;
  localparam logic [EV_W-1:0] EV_RESET = 3'h0;

  // packet count and derived byte count widths
  localparam int COUNT_W = 7;
  localparam int BYTES_W = 13;

  // answer given to an IN token
  typedef enum logic [2:0] {
    UIE_RESP_NONE,
    UIE_RESP_NAK,
    UIE_RESP_STALL,
    UIE_RESP_DATA0,
    UIE_RESP_DATA1
  } uie_resp_type;

endpackage

// ==== uie_setup_buf.sv ====
`timescale 1ns/100ps
module uie_setup_buf (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // byte write side from the packet receiver
  input wire logic wrEn,
  input wire logic [uie_pkg::SETUP_IDX_W-1:0] wrIdx,
  input wire logic [uie_pkg::DATA_W-1:0] wrByte,
  // read side for software
  input wire logic [uie_pkg::SETUP_IDX_W-1:0] rdIdx,
  output logic [uie_pkg::DATA_W-1:0] rdByte
);
  import uie_pkg::*;

  logic [DATA_W-1:0] store [SETUP_BYTES];

  // bytes land in arrival order, so word fields stay little-endian
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < SETUP_BYTES; i++) begin
        store[i] <= 8'h00;
      end
    end else if (wrEn) begin
      store[wrIdx] <= wrByte;
    end
  end

  // plain read mux, registered by the caller
  assign rdByte = store[rdIdx];
endmodule

// ==== uie_byte_count.sv ====
`timescale 1ns/100ps
module uie_byte_count (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // packet count and layout
  input wire logic isoMode,
  input wire logic [uie_pkg::COUNT_W-1:0] packetCount,
  input wire logic [uie_pkg::FRAME_W-1:0] frameByteCount,
  // bytes to move for the current packet
  output logic [uie_pkg::BYTES_W-1:0] byteCount
);
  import uie_pkg::*;

  logic [FRAME_W:0] bytesPerFrame;
  logic [BYTES_W-1:0] isoBytes;

  // field value plus one gives 1..32 bytes per sample
  assign bytesPerFrame = {1'b0, frameByteCount} + 6'h01;
  // widen both factors first so the product is never cut to seven bits
  assign isoBytes = BYTES_W'(packetCount) * BYTES_W'(bytesPerFrame);

  // samples for isochronous, bytes otherwise
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      byteCount <= 13'h0000;
    end else begin
      byteCount <= isoMode ? isoBytes : {6'h00, packetCount};
    end
  end
endmodule

// ==== uie_in_endpoint.sv ====
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/100ps
// Overview of operation
// - low six config bits mean different things for isochronous and other endpoints
// - bit 7 enables the endpoint; disabled endpoints ignore IN tokens
// - setup stage bytes are captured even while the endpoint is disabled
// - bit 6 selects isochronous layout, zero selects control/interrupt/bulk
// - non-iso toggle bit 5 flips after each acknowledged data packet
// - toggle zero sends DATA0, toggle one sends DATA1
// - bit 4 set alternates X and Y buffers, clear uses X only
// - non-iso stall bit 3 answers every token on an enabled endpoint with STALL, no software involved
// - bit 2 gates the endpoint interrupt request
// - non-iso bits 1 and 0 are reserved and have no effect
// - iso overrun flag bit 5 set by hardware, cleared only by software
// - iso bits 4:0 give bytes per sample as value plus one
// - the eight setup bytes are stored in a readable buffer
// - setup bytes sit at ff28 through ff2f in packet order
// - isochronous endpoints never answer NAK; empty status is ignored
// - iso packet count is samples, converted to bytes with bytes per sample
module uie_in_endpoint (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // register port
  input wire logic [uie_pkg::ADDR_W-1:0] regAddr,
  input wire logic [uie_pkg::DATA_W-1:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [uie_pkg::DATA_W-1:0] regRdData,
  // setup stage bytes from the packet receiver
  input wire logic setupStart,
  input wire logic setupByteValid,
  input wire logic [uie_pkg::DATA_W-1:0] setupByte,
  // IN transaction events from the packet engine
  input wire logic inToken,
  input wire logic hostAck,
  input wire logic hostNoAck,
  input wire logic overrunEvent,
  // buffer status held in the count bytes
  input wire logic xEmpty,
  input wire logic yEmpty,
  input wire logic [uie_pkg::COUNT_W-1:0] x_packet_count,
  input wire logic [uie_pkg::COUNT_W-1:0] y_packet_count,
  // answer to the packet engine
  output logic respValid,
  output uie_pkg::uie_resp_type respKind,
  output logic respUseY,
  output logic [uie_pkg::BYTES_W-1:0] respByteCount,
  output logic xEmptySet,
  output logic yEmptySet,
  // interrupt
  output logic irq
);
  import uie_pkg::*;

  typedef enum {UIE_IDLE, UIE_WAIT_ACK} uie_state_type;

  uie_state_type state_reg;
  logic [DATA_W-1:0] cfg_reg;
  logic useY_reg;
  logic [SETUP_IDX_W-1:0] setupIdx_reg;
  logic setupFull_reg;
  logic [EV_W-1:0] evStatus_reg;
  logic [EV_W-1:0] evMask_reg;
  logic [EV_W-1:0] evSet;
  logic respValid_reg;
  uie_resp_type respKind_reg;
  logic respUseY_reg;
  logic xEmptySet_reg;
  logic yEmptySet_reg;
  logic irq_reg;
  logic [DATA_W-1:0] regRdData_reg;
  logic [DATA_W-1:0] setupRdByte;
  logic [DATA_W-1:0] cfg_next;
  logic [COUNT_W-1:0] curCount;
  logic endpointOn;
  logic isoMode;
  logic toggle;
  logic dualBuf;
  logic stallOn;
  logic irqGate;
  logic curEmpty;
  logic setupSel;
  logic cfgWrite;
  logic statusWrite;
  logic maskWrite;
  logic xferDone;
  logic setupLast;
  logic overrunHit;

  // field views; bits 1:0 are decoded nowhere in non-iso mode
  assign endpointOn = cfg_reg[CFG_ON_BIT];
  assign isoMode = cfg_reg[CFG_ISO_BIT];
  assign toggle = cfg_reg[CFG_TOGGLE_BIT] & ~isoMode;
  assign dualBuf = cfg_reg[CFG_DUAL_BIT] & ~isoMode;
  assign stallOn = cfg_reg[CFG_STALL_BIT] & ~isoMode;
  assign irqGate = cfg_reg[CFG_IRQ_GATE_BIT] & ~isoMode;

  // register decode
  assign setupSel = regAddr[ADDR_W-1:SETUP_IDX_W] == SETUP_REQUEST_TYPE_ADDR[ADDR_W-1:SETUP_IDX_W];
  assign cfgWrite = regWrStb && regAddr == IN_ENDPOINT_CONFIG_ADDR;
  assign statusWrite = regWrStb && regAddr == EVENT_STATUS_ADDR;
  assign maskWrite = regWrStb && regAddr == EVENT_MASK_ADDR;

  // buffer in use: iso runs one circular buffer at X
  assign curEmpty = useY_reg ? yEmpty : xEmpty;
  assign curCount = (useY_reg && !isoMode) ? y_packet_count : x_packet_count;

  // completion and event sources
  assign xferDone = state_reg == UIE_WAIT_ACK && hostAck;
  assign setupLast = setupByteValid && !setupFull_reg && setupIdx_reg == 3'h7;
  assign overrunHit = overrunEvent && isoMode;

  // setup stage capture ignores the enable bit
  uie_setup_buf setupBuf (
    .clk(clk),
    .rstn(rstn),
    .wrEn(setupByteValid && !setupFull_reg),
    .wrIdx(setupIdx_reg),
    .wrByte(setupByte),
    .rdIdx(regAddr[SETUP_IDX_W-1:0]),
    .rdByte(setupRdByte)
  );

  // byte count for the packet about to go out
  uie_byte_count byteCnt (
    .clk(clk),
    .rstn(rstn),
    .isoMode(isoMode),
    .packetCount(curCount),
    .frameByteCount(cfg_reg[CFG_FRAME_BYTES_MSB:0]),
    .byteCount(respByteCount)
  );

  // setup byte index; a ninth byte is dropped, not wrapped over byte 0
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      setupIdx_reg <= 3'h0;
      setupFull_reg <= 1'b0;
    end else if (setupStart) begin
      setupIdx_reg <= 3'h0;
      setupFull_reg <= 1'b0;
    end else if (setupByteValid && !setupFull_reg) begin
      setupIdx_reg <= setupIdx_reg + 3'h1;
      setupFull_reg <= setupLast;
    end
  end

  // configuration byte: software write, then hardware updates
  always_comb begin
    cfg_next = cfg_reg;
    if (cfgWrite) begin
      cfg_next = regWrData;
    end
    // flip only after the host accepted a data packet
    if (xferDone && !isoMode) begin
      cfg_next[CFG_TOGGLE_BIT] = ~cfg_reg[CFG_TOGGLE_BIT];
    end
    // overrun set wins over a software clear in the same cycle
    if (overrunHit) begin
      cfg_next[CFG_OVERRUN_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_reg <= CFG_RESET;
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  // transaction sequencer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= UIE_IDLE;
    end else begin
      unique case (state_reg)
        UIE_IDLE: begin
          // only non-iso data packets wait for a handshake
          if (inToken && endpointOn && !isoMode && !stallOn && !curEmpty) begin
            state_reg <= UIE_WAIT_ACK;
          end
        end
        UIE_WAIT_ACK: begin
          if (hostAck || hostNoAck) begin
            state_reg <= UIE_IDLE;
          end
        end
      endcase
    end
  end

  // answer to a token, one cycle after it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      respValid_reg <= 1'b0;
      respKind_reg <= UIE_RESP_NONE;
      respUseY_reg <= 1'b0;
    end else begin
      respValid_reg <= 1'b0;
      if (inToken && state_reg == UIE_IDLE) begin
        respValid_reg <= 1'b1;
        respUseY_reg <= useY_reg;
        if (!endpointOn) begin
          respKind_reg <= UIE_RESP_NONE;
        end else if (stallOn) begin
          respKind_reg <= UIE_RESP_STALL;
        end else if (isoMode) begin
          respKind_reg <= UIE_RESP_DATA0;
        end else if (curEmpty) begin
          respKind_reg <= UIE_RESP_NAK;
        end else begin
          respKind_reg <= toggle ? UIE_RESP_DATA1 : UIE_RESP_DATA0;
        end
      end
    end
  end

  // ping-pong pointer; single buffer mode stays on X
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      useY_reg <= 1'b0;
    end else if (!dualBuf) begin
      useY_reg <= 1'b0;
    end else if (xferDone) begin
      useY_reg <= ~useY_reg;
    end
  end

  // mark the drained buffer empty after success
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      xEmptySet_reg <= 1'b0;
      yEmptySet_reg <= 1'b0;
    end else begin
      xEmptySet_reg <= xferDone && !useY_reg;
      yEmptySet_reg <= xferDone && useY_reg;
    end
  end

  // sticky events, write one to clear, set beats clear
  assign evSet = {overrunHit, setupLast, xferDone};

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      evStatus_reg <= EV_RESET;
    end else if (statusWrite) begin
      evStatus_reg <= (evStatus_reg & ~regWrData[EV_W-1:0]) | evSet;
    end else begin
      evStatus_reg <= evStatus_reg | evSet;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      evMask_reg <= EV_RESET;
    end else if (maskWrite) begin
      evMask_reg <= regWrData[EV_W-1:0];
    end
  end

  // the config gate keeps irq low even with status pending
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irqGate && |(evStatus_reg & evMask_reg);
    end
  end

  // read data stands for one cycle only; unmapped reads give zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      regRdData_reg <= 8'h00;
    end else if (regRdStb) begin
      if (setupSel) begin
        regRdData_reg <= setupRdByte;
      end else if (regAddr == IN_ENDPOINT_CONFIG_ADDR) begin
        regRdData_reg <= cfg_reg;
      end else if (regAddr == EVENT_STATUS_ADDR) begin
        regRdData_reg <= {5'h00, evStatus_reg};
      end else if (regAddr == EVENT_MASK_ADDR) begin
        regRdData_reg <= {5'h00, evMask_reg};
      end else begin
        regRdData_reg <= 8'h00;
      end
    end else begin
      regRdData_reg <= 8'h00;
    end
  end

  // outputs straight from flops
  assign regRdData = regRdData_reg;
  assign respValid = respValid_reg;
  assign respKind = respKind_reg;
  assign respUseY = respUseY_reg;
  assign xEmptySet = xEmptySet_reg;
  assign yEmptySet = yEmptySet_reg;
  assign irq = irq_reg;
endmodule

// ==== uie_in_endpoint_props.sv ====
`timescale 1ns/100ps
module uie_in_endpoint_props (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // register port
  input wire logic [15:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  input wire logic [7:0] regRdData,
  // handshake and buffer count
  input wire logic hostAck,
  input wire logic [6:0] x_packet_count,
  // answer and interrupt
  input wire logic respValid,
  input wire uie_pkg::uie_resp_type respKind,
  input wire logic respUseY,
  input wire logic [12:0] respByteCount,
  input wire logic xEmptySet,
  input wire logic yEmptySet,
  input wire logic irq
);
  import uie_pkg::*;
  logic [7:0] cfgSw;
  // shadow of software writes; only bits that hardware never touches are used
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfgSw <= 8'h00;
    end else if (regWrStb && regAddr == IN_ENDPOINT_CONFIG_ADDR) begin
      cfgSw <= regWrData;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // a buffer being handed back to software
  sequence emptyMark;
    xEmptySet || yEmptySet;
  endsequence
  rd_data_window_a: assert property (!$past(regRdStb) |-> regRdData == 8'h00)
    else $error("read data outside its cycle");
  resp_one_pulse_a: assert property (respValid |=> !respValid)
    else $error("answer longer than one cycle");
  disabled_none_a: assert property (respValid && !$past(cfgSw[7]) |-> respKind == UIE_RESP_NONE)
    else $error("disabled endpoint answered");
  stall_answer_a: assert property (respValid && $past(cfgSw[7] && cfgSw[3] && !cfgSw[6])
    |-> respKind == UIE_RESP_STALL)
    else $error("stall not answered");
  iso_no_nak_a: assert property (respValid && $past(cfgSw[6]) |-> respKind != UIE_RESP_NAK)
    else $error("iso endpoint sent nak");
  single_buf_x_a: assert property (respValid && !$past(cfgSw[4]) |-> !respUseY)
    else $error("y buffer used in single mode");
  ack_mark_a: assert property (emptyMark |-> $past(hostAck) && (cfgSw[4] || !yEmptySet))
    else $error("buffer marked empty without ack");
  irq_gate_a: assert property (irq |-> $past(cfgSw[2]) && !$past(cfgSw[6]))
    else $error("interrupt raised while gated");
  iso_bytes_a: assert property ($past(cfgSw[6]) |->
    respByteCount == 13'($past(x_packet_count)) * (13'($past(cfgSw[4:0])) + 13'h1))
    else $error("iso byte count wrong");
endmodule
bind uie_in_endpoint uie_in_endpoint_props props_u (.*);

// ==== uie_host_model.sv ====
`timescale 1ns/100ps
// host side: acks each data packet after a delay, or lets it time out
module uie_host_model (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // device answer and behaviour select
  input wire logic respValid,
  input wire uie_pkg::uie_resp_type respKind,
  input wire logic dropAck,
  // handshakes
  output logic hostAck,
  output logic hostNoAck
);
  import uie_pkg::*;
  logic [1:0] waitCnt;
  // only data packets get a handshake; stall and nak need none from the host
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      waitCnt <= 2'h0;
      hostAck <= 1'b0;
      hostNoAck <= 1'b0;
    end else begin
      hostAck <= 1'b0;
      hostNoAck <= 1'b0;
      if (respValid && (respKind == UIE_RESP_DATA0 || respKind == UIE_RESP_DATA1)) begin
        waitCnt <= 2'h2;
      end else if (waitCnt != 2'h0) begin
        waitCnt <= waitCnt - 2'h1;
        hostAck <= (waitCnt == 2'h1) && !dropAck;
        hostNoAck <= (waitCnt == 2'h1) && dropAck;
      end
    end
  end
endmodule

// ==== uie_in_endpoint_tb_top.sv ====
`timescale 1ns/100ps
module uie_in_endpoint_tb_top;
  import uie_pkg::*;
  typedef struct {logic [7:0] cfg; logic empty; uie_resp_type kind;} uie_row_type;
  logic clk, rstn, regWrStb, regRdStb, setupStart, setupByteValid, inToken;
  logic hostAck, hostNoAck, overrunEvent, xEmpty, respValid, respUseY;
  logic xEmptySet, yEmptySet, irq, dropAck;
  logic [15:0] regAddr;
  logic [7:0] regWrData, regRdData, setupByte;
  logic [6:0] xCount;
  logic [12:0] respByteCount;
  uie_resp_type respKind;
  int errCount, comparisons;
  // config, x empty, expected answer
  uie_row_type rows [7] = '{'{8'h00, 1'b0, UIE_RESP_NONE}, '{8'h88, 1'b0, UIE_RESP_STALL},
    '{8'h8b, 1'b1, UIE_RESP_STALL}, '{8'h80, 1'b1, UIE_RESP_NAK}, '{8'h83, 1'b0, UIE_RESP_DATA0},
    '{8'ha0, 1'b0, UIE_RESP_DATA1}, '{8'hcb, 1'b1, UIE_RESP_DATA0}};
  uie_in_endpoint dut_u (.clk(clk), .rstn(rstn), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .setupStart(setupStart),
    .setupByteValid(setupByteValid), .setupByte(setupByte), .inToken(inToken), .hostAck(hostAck),
    .hostNoAck(hostNoAck), .overrunEvent(overrunEvent), .xEmpty(xEmpty), .yEmpty(1'b0),
    .x_packet_count(xCount), .y_packet_count(7'h00), .respValid(respValid), .respKind(respKind),
    .respUseY(respUseY), .respByteCount(respByteCount), .xEmptySet(xEmptySet),
    .yEmptySet(yEmptySet), .irq(irq));
  uie_host_model host_u (.clk(clk), .rstn(rstn), .respValid(respValid), .respKind(respKind),
    .dropAck(dropAck), .hostAck(hostAck), .hostNoAck(hostNoAck));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errCount++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic endSim();
    $display("mismatches %0d comparisons %0d", errCount, comparisons);
    if (errCount == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    regWrStb <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWrStb <= 1'b0;
  endtask
  // read data only stands in the cycle after the strobe, so sample it there
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk);
    regRdStb <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRdStb <= 1'b0;
    #1 check(16'(regRdData), 16'(exp));
  endtask
  task automatic tok(input uie_resp_type kind, input logic useY);
    @(posedge clk);
    inToken <= 1'b1;
    @(posedge clk);
    inToken <= 1'b0;
    #1 check(16'(respValid), 16'h0001);
    check(16'(respKind), 16'(kind));
    check(16'(respUseY), 16'(useY));
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // the whole run is well under a thousand cycles
  initial begin
    #200000;
    errCount++;
    endSim();
  end
  initial begin
    {rstn, regWrStb, regRdStb, setupStart, setupByteValid, inToken, overrunEvent, xEmpty, dropAck} = '0;
    {regAddr, regWrData, setupByte, xCount} = '0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    rd(IN_ENDPOINT_CONFIG_ADDR, 8'h00);
    rd(EVENT_STATUS_ADDR, 8'h00);
    for (int i = 0; i < 7; i++) begin
      wr(IN_ENDPOINT_CONFIG_ADDR, rows[i].cfg);
      xEmpty <= rows[i].empty;
      tok(rows[i].kind, 1'b0);
      repeat (5) @(posedge clk);
    end
    // setup capture with the endpoint off, one byte too many
    wr(IN_ENDPOINT_CONFIG_ADDR, 8'h00);
    setupStart <= 1'b1;
    for (int k = 0; k < 9; k++) begin
      @(posedge clk);
      setupStart <= 1'b0;
      setupByteValid <= 1'b1;
      setupByte <= 8'h40 + 8'(k);
    end
    @(posedge clk);
    setupByteValid <= 1'b0;
    wr(SETUP_REQUEST_TYPE_ADDR, 8'hff);
    for (int k = 0; k < 8; k++) rd(SETUP_REQUEST_TYPE_ADDR + 16'(k), 8'h40 + 8'(k));
    rd(16'hff00, 8'h00);
    rd(EVENT_STATUS_ADDR, 8'h03);
    wr(EVENT_STATUS_ADDR, 8'h03);
    // toggle, buffer alternation and interrupt gate
    wr(EVENT_MASK_ADDR, 8'h01);
    wr(IN_ENDPOINT_CONFIG_ADDR, 8'h94);
    xEmpty <= 1'b0;
    tok(UIE_RESP_DATA0, 1'b0);
    repeat (5) @(posedge clk);
    #1 check(16'(irq), 16'h0001);
    rd(IN_ENDPOINT_CONFIG_ADDR, 8'hb4);
    tok(UIE_RESP_DATA1, 1'b1);
    repeat (4) @(posedge clk);
    rd(IN_ENDPOINT_CONFIG_ADDR, 8'h94);
    wr(EVENT_STATUS_ADDR, 8'h01);
    dropAck <= 1'b1;
    tok(UIE_RESP_DATA0, 1'b0);
    repeat (4) @(posedge clk);
    rd(IN_ENDPOINT_CONFIG_ADDR, 8'h94);
    check(16'(irq), 16'h0000);
    dropAck <= 1'b0;
    wr(IN_ENDPOINT_CONFIG_ADDR, 8'h90);
    tok(UIE_RESP_DATA0, 1'b0);
    repeat (5) @(posedge clk);
    #1 check(16'(irq), 16'h0000);
    rd(EVENT_STATUS_ADDR, 8'h01);
    // iso overrun flag and sample to byte conversion
    xCount <= 7'h05;
    wr(IN_ENDPOINT_CONFIG_ADDR, 8'hc3);
    overrunEvent <= 1'b1;
    @(posedge clk);
    overrunEvent <= 1'b0;
    rd(IN_ENDPOINT_CONFIG_ADDR, 8'he3);
    rd(IN_ENDPOINT_CONFIG_ADDR, 8'he3);
    check(16'(respByteCount), 16'h0014);
    wr(IN_ENDPOINT_CONFIG_ADDR, 8'hc3);
    rd(IN_ENDPOINT_CONFIG_ADDR, 8'hc3);
    endSim();
  end
endmodule
